// ---- rtl/nv_access_ctrl.sv ----
// Purpose: cpu access to the 64-byte nonvolatile data store via i/o regs
// Assumes: single-cycle i/o writes and reads, osc_tick from calibrated osc
// Notes: programming engine is reset only by pwr_rst, cpu side by rst

`timescale 1ns/10ps

module nv_access_ctrl
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic pwr_rst,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_we,
  input wire logic io_re,
  output logic [7:0] io_rdata,
  input wire logic global_irq_enable,
  input wire logic osc_tick,
  output logic cpu_stall,
  output logic ready_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [5:0] nv_byte_address;
  logic [7:0] nv_byte_data;
  logic [1:0] prog_mode_field;
  logic ready_irq_enable;
  logic master_prog_enable;
  logic [2:0] mpe_count;
  logic [2:0] stall_count;
  logic [5:0] prog_addr;
  logic [7:0] prog_data;
  logic [1:0] prog_mode;

  // next values and decode
  logic [5:0] next_address;
  logic [7:0] next_data;
  logic [1:0] next_mode;
  logic next_mpe;
  logic [2:0] next_mpe_count;
  logic [2:0] next_stall;
  logic [7:0] next_rdata;
  logic [7:0] control_view;
  logic [1:0] start_mode;
  logic [11:0] start_ticks;
  logic wr_ctrl;
  logic wr_data;
  logic wr_addr;
  logic start_go;
  logic rd_go;
  logic prog_strobe_busy;
  logic prog_done;
  logic [7:0] array_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  assign wr_ctrl = io_we && (io_addr == nv_access_pkg::OFS_CONTROL);
  assign wr_data = io_we && (io_addr == nv_access_pkg::OFS_DATA);
  assign wr_addr = io_we && (io_addr == nv_access_pkg::OFS_ADDRESS);

  assign start_mode = io_wdata[nv_access_pkg::MODE_HI:nv_access_pkg::MODE_LO];
  assign start_go = wr_ctrl && io_wdata[nv_access_pkg::PE_BIT] &&
    master_prog_enable && !prog_strobe_busy && !rst &&
    (start_mode != nv_access_pkg::MODE_RSVD);

  assign rd_go = wr_ctrl && io_wdata[nv_access_pkg::RE_BIT] &&
    !prog_strobe_busy && !start_go;

  assign start_ticks = (start_mode == nv_access_pkg::MODE_ATOMIC) ?
    nv_access_pkg::ATOMIC_TICKS : nv_access_pkg::SPLIT_TICKS;

  ////////////////////////////////////////////////////////////////////////////
  // mode frozen while busy
  assign next_mode = (rst && !prog_strobe_busy) ? nv_access_pkg::MODE_RESET :
    (wr_ctrl && !prog_strobe_busy) ? start_mode : prog_mode_field;

  // mode sits in the power domain so a busy reset cannot disturb it
  always_ff @(posedge mclk or posedge pwr_rst)
  begin
    if (pwr_rst)
      prog_mode_field <= nv_access_pkg::MODE_RESET;
    else
      prog_mode_field <= next_mode;
  end

  ////////////////////////////////////////////////////////////////////////////
  // address locked while busy
  assign next_address = (wr_addr && !prog_strobe_busy) ?
    io_wdata[nv_access_pkg::ADDR_BITS-1:0] : nv_byte_address;

  assign next_data = rd_go ? array_rdata :
    wr_data ? io_wdata : nv_byte_data;

  // address and data registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      nv_byte_address <= nv_access_pkg::ADDR_RESET;
      nv_byte_data <= nv_access_pkg::DATA_RESET;
    end
    else
    begin
      nv_byte_address <= next_address;
      nv_byte_data <= next_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // four-cycle enable window
  // a rewrite of one restarts the window, which software may rely on
  assign next_mpe = (wr_ctrl && io_wdata[nv_access_pkg::MPE_BIT]) ? 1'b1 :
    (mpe_count == 3'h1) ? 1'b0 : master_prog_enable;
  assign next_mpe_count = (wr_ctrl && io_wdata[nv_access_pkg::MPE_BIT]) ?
    nv_access_pkg::MPE_WINDOW :
    (mpe_count != 3'h0) ? mpe_count - 3'h1 : 3'h0;

  assign next_stall = start_go ? nv_access_pkg::PROG_STALL :
    rd_go ? nv_access_pkg::READ_STALL :
    (stall_count != 3'h0) ? stall_count - 3'h1 : 3'h0;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ready_irq_enable <= 1'b0;
      master_prog_enable <= 1'b0;
      mpe_count <= 3'h0;
      stall_count <= 3'h0;
    end
    else
    begin
      if (wr_ctrl)
        ready_irq_enable <= io_wdata[nv_access_pkg::RIE_BIT];
      master_prog_enable <= next_mpe;
      mpe_count <= next_mpe_count;
      stall_count <= next_stall;
    end
  end

  assign cpu_stall = (stall_count != 3'h0);

  ////////////////////////////////////////////////////////////////////////////
  // operands held in power domain
  always_ff @(posedge mclk or posedge pwr_rst)
  begin
    if (pwr_rst)
    begin
      prog_addr <= nv_access_pkg::ADDR_RESET;
      prog_data <= nv_access_pkg::DATA_RESET;
      prog_mode <= nv_access_pkg::MODE_RESET;
    end
    else if (start_go)
    begin
      prog_addr <= nv_byte_address;
      prog_data <= nv_byte_data;
      prog_mode <= start_mode;
    end
  end

  nv_prog_timer u_timer
  (
    .mclk(mclk),
    .pwr_rst(pwr_rst),
    .osc_tick(osc_tick),
    .start(start_go),
    .load_ticks(start_ticks),
    .busy(prog_strobe_busy),
    .done(prog_done)
  );

  nv_byte_array u_array
  (
    .mclk(mclk),
    .rd_addr(nv_byte_address),
    .rd_data(array_rdata),
    .commit(prog_done),
    .wr_addr(prog_addr),
    .wr_mode(prog_mode),
    .wr_data(prog_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // top bits and read strobe read zero
  assign control_view = {2'h0, prog_mode_field, ready_irq_enable,
    master_prog_enable, prog_strobe_busy, 1'b0};

  assign next_rdata =
    (io_addr == nv_access_pkg::OFS_CONTROL) ? control_view :
    (io_addr == nv_access_pkg::OFS_DATA) ? nv_byte_data :
    (io_addr == nv_access_pkg::OFS_ADDRESS) ? {2'h0, nv_byte_address} :
    8'h00;

  // read data registered one cycle after io_re, held otherwise
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      io_rdata <= 8'h00;
    else if (io_re)
      io_rdata <= next_rdata;
  end

  assign ready_irq = ready_irq_enable && global_irq_enable &&
    !prog_strobe_busy;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst || pwr_rst);

  chk_mpe_window: assert property (
    (wr_ctrl && io_wdata[nv_access_pkg::MPE_BIT]) ##1
    (!(wr_ctrl && io_wdata[nv_access_pkg::MPE_BIT]))[*4]
    |=> !master_prog_enable)
  else $error("master enable did not clear after four cycles");

  chk_mpe_held: assert property (
    (wr_ctrl && io_wdata[nv_access_pkg::MPE_BIT]) |=> master_prog_enable[*4])
  else $error("master enable dropped inside its window");

  chk_start_cause: assert property (
    $rose(prog_strobe_busy) |-> $past(master_prog_enable) && $past(wr_ctrl))
  else $error("programming started without master enable");

  chk_mode_frozen: assert property (
    (prog_strobe_busy && wr_ctrl) |=> $stable(prog_mode_field))
  else $error("mode changed while busy");

  chk_addr_lock: assert property (
    (prog_strobe_busy && wr_addr) |=> $stable(nv_byte_address))
  else $error("address changed while busy");

  chk_prog_stall: assert property (
    start_go |=> cpu_stall[*2] ##1 !cpu_stall)
  else $error("program stall not two cycles");

  chk_read_stall: assert property (
    rd_go |=> cpu_stall[*4] ##1 !cpu_stall)
  else $error("read stall not four cycles");

  chk_read_fetch: assert property (
    rd_go |=> nv_byte_data == $past(array_rdata))
  else $error("read did not load the fetched byte");

  chk_read_refused: assert property (
    (prog_strobe_busy && wr_ctrl) |-> !rd_go ##1 !cpu_stall)
  else $error("read accepted while busy");

  chk_irq_level: assert property (
    ready_irq == (ready_irq_enable && global_irq_enable && !prog_strobe_busy))
  else $error("ready irq level wrong");

  chk_busy_clear: assert property (
    prog_done |=> !prog_strobe_busy)
  else $error("busy not cleared at end of programming");

  // the data register is a full byte, so every other offset counts
  chk_top_zero: assert property (
    (io_re && (io_addr != nv_access_pkg::OFS_DATA)) |=>
    io_rdata[7:6] == 2'h0)
  else $error("upper read bits not zero");

  chk_irq_ready: assert property (
    (prog_done && ready_irq_enable && global_irq_enable && !wr_ctrl) |=>
    (ready_irq || !global_irq_enable))
  else $error("ready irq missing after programming ended");

  chk_rsvd_refused: assert property (
    (wr_ctrl && io_wdata[nv_access_pkg::PE_BIT] && !prog_strobe_busy &&
    (start_mode == nv_access_pkg::MODE_RSVD)) |=> !prog_strobe_busy)
  else $error("reserved mode started programming");

endmodule // nv_access_ctrl

// ---- rtl/nv_access_pkg.sv ----
// Purpose: shared constants for the byte-wide nonvolatile access controller
// Assumes: i/o offsets are local choices, timing from oscillator ticks
// Notes: every offset, field position, cycle count and mode, address and data reset value lives here

package nv_access_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // i/o register offsets (6-bit i/o space)
  localparam logic [5:0] OFS_CONTROL = 6'h1c;
  localparam logic [5:0] OFS_DATA = 6'h1d;
  localparam logic [5:0] OFS_ADDRESS = 6'h1e;

  ////////////////////////////////////////////////////////////////////////////
  // control register field positions
  localparam int MODE_HI = 5;
  localparam int MODE_LO = 4;
  localparam int RIE_BIT = 3;
  localparam int MPE_BIT = 2;
  localparam int PE_BIT = 1;
  localparam int RE_BIT = 0;

  // address layout: six live bits select 64 linear byte locations
  localparam int ADDR_BITS = 6;
  localparam int DEPTH = 64;

  ////////////////////////////////////////////////////////////////////////////
  // programming modes
  localparam logic [1:0] MODE_ATOMIC = 2'h0;
  localparam logic [1:0] MODE_ERASE = 2'h1;
  localparam logic [1:0] MODE_WRITE = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and the erased byte value
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [5:0] ADDR_RESET = 6'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // cycle counts on mclk
  localparam logic [2:0] MPE_WINDOW = 3'h4;
  localparam logic [2:0] PROG_STALL = 3'h2;
  localparam logic [2:0] READ_STALL = 3'h4;

  // programming times, counted in calibrated-oscillator ticks
  localparam int TICK_NS = 1000;
  localparam int ATOMIC_US = 3400;
  localparam int SPLIT_US = 1800;
  localparam int ATOMIC_TICKS_I = (ATOMIC_US * 1000 + TICK_NS - 1) / TICK_NS;
  localparam int SPLIT_TICKS_I = (SPLIT_US * 1000 + TICK_NS - 1) / TICK_NS;
  localparam logic [11:0] ATOMIC_TICKS = ATOMIC_TICKS_I[11:0];
  localparam logic [11:0] SPLIT_TICKS = SPLIT_TICKS_I[11:0];

endpackage

// ---- rtl/nv_byte_array.sv ----
// Purpose: 64-byte storage array with erase, write and atomic commit
// Assumes: one commit pulse per programming operation
// Notes: write-only can only clear bits, so an unerased byte is corrupted

`timescale 1ns/10ps

module nv_byte_array
(
  input wire logic mclk,
  input wire logic [5:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic commit,
  input wire logic [5:0] wr_addr,
  input wire logic [1:0] wr_mode,
  input wire logic [7:0] wr_data
);

  logic [7:0] cells [0:nv_access_pkg::DEPTH-1];

  ////////////////////////////////////////////////////////////////////////////
  // combinational fetch so a read finishes inside the strobe write
  assign rd_data = cells[rd_addr];

  // store the result of the finished operation
  always_ff @(posedge mclk)
  begin
    if (commit)
    begin
      case (wr_mode)
        nv_access_pkg::MODE_ATOMIC: cells[wr_addr] <= wr_data;
        nv_access_pkg::MODE_ERASE: cells[wr_addr] <= nv_access_pkg::ERASED_BYTE;
        nv_access_pkg::MODE_WRITE: cells[wr_addr] <= cells[wr_addr] & wr_data;
        default: cells[wr_addr] <= cells[wr_addr];
      endcase
    end
  end

endmodule // nv_byte_array

// ---- rtl/nv_prog_timer.sv ----
// Purpose: programming duration timer driven by oscillator ticks
// Assumes: osc_tick is a one-cycle pulse synchronous to mclk
// Notes: reset only by pwr_rst so a running operation survives rst

`timescale 1ns/10ps

module nv_prog_timer
(
  input wire logic mclk,
  input wire logic pwr_rst,
  input wire logic osc_tick,
  input wire logic start,
  input wire logic [11:0] load_ticks,
  output logic busy,
  output logic done
);

  typedef enum logic {T_IDLE, T_RUN} timer_state_e;

  timer_state_e state;
  timer_state_e next_state;
  logic [11:0] count;
  logic [11:0] next_count;

  ////////////////////////////////////////////////////////////////////////////
  // time from oscillator
  assign done = (state == T_RUN) && osc_tick && (count == 12'h001);
  assign busy = (state == T_RUN);

  // next state and count
  always_comb
  begin
    next_state = state;
    next_count = count;
    case (state)
      T_IDLE:
      begin
        if (start)
        begin
          next_state = T_RUN;
          next_count = load_ticks;
        end
      end
      T_RUN:
      begin
        if (done)
          next_state = T_IDLE;
        else if (osc_tick)
          next_count = count - 12'h001;
      end
      default: next_state = T_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge pwr_rst)
  begin
    if (pwr_rst)
    begin
      state <= T_IDLE;
      count <= 12'h000;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
    end
  end

endmodule // nv_prog_timer

// ---- verif/eeprom_byte_access_ctrl_bench.sv ----
// Purpose: self-checking bench for the nonvolatile byte access controller
// Assumes: one-cycle i/o strobes, osc tick on every second mclk cycle
// Notes: durations are judged in a window, tick phase at start is free

`timescale 1ns/10ps

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end

module eeprom_byte_access_ctrl_bench;

  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic pwr_rst = 1'b1;
  logic [5:0] io_addr = 6'h00;
  logic [7:0] io_wdata = 8'h00;
  logic io_we = 1'b0;
  logic io_re = 1'b0;
  logic [7:0] io_rdata;
  logic global_irq_enable = 1'b0;
  logic osc_tick = 1'b0;
  logic tick_en = 1'b1;
  logic cpu_stall;
  logic ready_irq;
  int n_fail = 0;
  int total_checks = 0;

  ////////////////////////////////////////////////////////////////////////////
  // clock, oscillator ticks and device
  always #4 mclk = ~mclk;

  // ticks at half the clock rate so time cannot be mistaken for mclk cycles
  always @(posedge mclk)
    osc_tick <= tick_en & ~osc_tick;

  nv_access_ctrl u_nv_access_ctrl (
    .mclk(mclk), .rst(rst), .pwr_rst(pwr_rst), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re), .io_rdata(io_rdata),
    .global_irq_enable(global_irq_enable), .osc_tick(osc_tick),
    .cpu_stall(cpu_stall), .ready_irq(ready_irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus tasks: a write also counts the stall cycles it causes
  task close_out;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task wr(input logic [5:0] a, input logic [7:0] v, output int ns);
    io_addr <= a;
    io_wdata <= v;
    io_we <= 1'b1;
    @(posedge mclk);
    io_we <= 1'b0;
    ns = 0;
    // no access is made while the cpu is held
    for (int i = 0; i < 10; i++)
    begin
      #1;
      if (cpu_stall !== 1'b1)
        break;
      ns++;
      @(posedge mclk);
    end
    if (ns == 10)
    begin
      n_fail++;
      $display("[FAIL] %0t stall never ended", $time);
    end
    @(posedge mclk);
  endtask

  task rd(input logic [5:0] a, output logic [7:0] v);
    io_addr <= a;
    io_re <= 1'b1;
    @(posedge mclk);
    io_re <= 1'b0;
    #1 v = io_rdata;
    @(posedge mclk);
  endtask

  task pulse_rst;
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task t_reset;
    logic [7:0] d;
    int ns;
    rd(nv_access_pkg::OFS_CONTROL, d);
    `CHK(d, 8'h00)
    rd(6'h00, d);
    `CHK(d, 8'h00)
    wr(nv_access_pkg::OFS_CONTROL, 8'he8, ns);
    rd(nv_access_pkg::OFS_CONTROL, d);
    `CHK(d, 8'h28)
    pulse_rst();
    rd(nv_access_pkg::OFS_CONTROL, d);
    `CHK(d, 8'h00)
  endtask

  task t_regs;
    logic [7:0] d;
    int ns;
    wr(nv_access_pkg::OFS_ADDRESS, 8'hff, ns);
    rd(nv_access_pkg::OFS_ADDRESS, d);
    `CHK(d, 8'h3f)
    wr(nv_access_pkg::OFS_DATA, 8'ha5, ns);
    rd(nv_access_pkg::OFS_DATA, d);
    `CHK(d, 8'ha5)
  endtask

  task t_irq;
    int ns;
    global_irq_enable <= 1'b1;
    wr(nv_access_pkg::OFS_CONTROL, 8'h08, ns);
    `CHK(ready_irq, 1'b1)
    global_irq_enable <= 1'b0;
    @(posedge mclk);
    #1 `CHK(ready_irq, 1'b0)
    @(posedge mclk);
    global_irq_enable <= 1'b1;
    wr(nv_access_pkg::OFS_CONTROL, 8'h00, ns);
    `CHK(ready_irq, 1'b0)
  endtask

  // enable seen two cycles on, gone at six; a late strobe does nothing
  task t_window;
    logic [7:0] d;
    int ns;
    wr(nv_access_pkg::OFS_CONTROL, 8'h04, ns);
    rd(nv_access_pkg::OFS_CONTROL, d);
    `CHK(d, 8'h04)
    repeat (2) @(posedge mclk);
    rd(nv_access_pkg::OFS_CONTROL, d);
    `CHK(d, 8'h00)
    wr(nv_access_pkg::OFS_CONTROL, 8'h04, ns);
    repeat (3) @(posedge mclk);
    wr(nv_access_pkg::OFS_CONTROL, 8'h12, ns);
    `CHK(ns, 0)
    rd(nv_access_pkg::OFS_CONTROL, d);
    `CHK(d[1], 1'b0)
  endtask

  task t_prog(input logic [1:0] m, input logic [5:0] a, input logic [7:0] v,
              input int gap, input int pause, input bit mid_rst);
    logic [7:0] d;
    int ns;
    int ticks;
    int cyc;
    int i;
    realtime t0;
    bit go;
    go = (m != nv_access_pkg::MODE_RSVD);
    ticks = (m == nv_access_pkg::MODE_ATOMIC) ?
      int'(nv_access_pkg::ATOMIC_TICKS) : int'(nv_access_pkg::SPLIT_TICKS);
    wr(nv_access_pkg::OFS_CONTROL, {2'h0, m, 4'h0}, ns);
    wr(nv_access_pkg::OFS_ADDRESS, {2'h0, a}, ns);
    wr(nv_access_pkg::OFS_DATA, v, ns);
    wr(nv_access_pkg::OFS_CONTROL, {2'h0, m, 4'hc}, ns);
    repeat (gap) @(posedge mclk);
    t0 = $realtime;
    wr(nv_access_pkg::OFS_CONTROL, {2'h0, m, 4'ha}, ns);
    `CHK(ns, go ? 2 : 0)
    rd(nv_access_pkg::OFS_CONTROL, d);
    `CHK(d[1], go)
    if (!go)
      return;
    `CHK(ready_irq, 1'b0)
    // a held oscillator must stretch the busy time by the pause
    if (pause > 0)
    begin
      tick_en <= 1'b0;
      repeat (pause) @(posedge mclk);
      tick_en <= 1'b1;
    end
    // every mode, address and read request below must be refused while the array is busy
    wr(nv_access_pkg::OFS_CONTROL, {2'h0, ~m, 4'h8}, ns);
    rd(nv_access_pkg::OFS_CONTROL, d);
    `CHK(d, {2'h0, m, 4'ha})
    wr(nv_access_pkg::OFS_ADDRESS, {2'h0, ~a}, ns);
    rd(nv_access_pkg::OFS_ADDRESS, d);
    `CHK(d, {2'h0, a})
    wr(nv_access_pkg::OFS_CONTROL, {2'h0, m, 4'h9}, ns);
    `CHK(ns, 0)
    rd(nv_access_pkg::OFS_DATA, d);
    `CHK(d, v)
    if (mid_rst)
    begin
      pulse_rst();
      rd(nv_access_pkg::OFS_CONTROL, d);
      `CHK(d, {2'h0, m, 4'h2})
    end
    for (i = 0; i < 9000; i++)
    begin
      if (mid_rst)
        rd(nv_access_pkg::OFS_CONTROL, d);
      else
        @(posedge mclk);
      if (mid_rst ? d[1] === 1'b0 : ready_irq === 1'b1)
        break;
    end
    // a hang counts once and the run carries on to the closing report
    if (i == 9000)
    begin
      n_fail++;
      $display("[FAIL] %0t busy never cleared", $time);
      return;
    end
    cyc = int'(($realtime - t0) / 8.0);
    if (!mid_rst)
      `CHK(cyc > 2 * ticks + pause - 8 && cyc < 2 * ticks + pause + 8,
           1'b1)
    rd(nv_access_pkg::OFS_CONTROL, d);
    `CHK(d[1], 1'b0)
  endtask

  task t_read(input logic [5:0] a, input logic [7:0] v);
    logic [7:0] d;
    int ns;
    rd(nv_access_pkg::OFS_CONTROL, d);
    `CHK(d[1], 1'b0)
    wr(nv_access_pkg::OFS_ADDRESS, {2'h0, a}, ns);
    wr(nv_access_pkg::OFS_CONTROL, 8'h01, ns);
    `CHK(ns, 4)
    rd(nv_access_pkg::OFS_DATA, d);
    `CHK(d, v)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    pwr_rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_regs();
    t_irq();
    t_window();
    t_prog(nv_access_pkg::MODE_ATOMIC, 6'h05, 8'h3c, 0, 400, 1'b0);
    t_read(6'h05, 8'h3c);
    t_prog(nv_access_pkg::MODE_ERASE, 6'h05, 8'h00, 0, 0, 1'b1);
    t_read(6'h05, nv_access_pkg::ERASED_BYTE);
    // byte was erased just before
    // strobe on the last cycle of the enable window
    t_prog(nv_access_pkg::MODE_WRITE, 6'h05, 8'h5a, 2, 0, 1'b0);
    t_read(6'h05, 8'h5a);
    t_prog(nv_access_pkg::MODE_RSVD, 6'h05, 8'h77, 0, 0, 1'b0);
    t_read(6'h05, 8'h5a);
    close_out();
  end

endmodule // eeprom_byte_access_ctrl_bench
